// ==== rtl/cdco_top.sv ====
// Implementation choice: register access over APB.
module cdco_top
   import cdco_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic sysclk_tick,
   output logic [2:0] master_clock_source,
   input wire logic reset_pin_option,
   input wire logic shared_pin_in,
   output logic shared_pin_out,
   output logic shared_pin_oe_n,
   output logic reset_request,
   output logic reset_indicator_output,
   input wire logic serial_tx_data,
   output logic serial_rx_data,
   input wire logic [2:0] serial_rx_pin,
   output logic [2:0] serial_tx_pin,
   output logic [2:0] serial_tx_pin_oe_n,
   input wire logic timer0_clock_in,
   input wire logic timer2_clock_in,
   output logic timer0_clock_output,
   output logic timer0_clock_output_oe_n,
   output logic timer2_clock_output,
   output logic timer2_clock_output_oe_n
);
   logic [7:0] clk_div;
   logic [1:0] pin_grp;
   logic [7:0] clko_en;
   logic [7:0] misc;
   logic wr_en;
   logic rd_setup;
   logic addr_ok;
   logic [31:0] next_rdata;
   logic [2:0] div_exp;
   logic [6:0] div_mask;
   logic [6:0] div_cnt;
   logic [1:0] out_sel_act;
   logic mclk_out;
   logic [1:0] act_grp;
   logic strap_taken;
   logic rst_mode;
   logic [1:0] rst_hi_cnt;
   logic relay;

   // Bus decode: zero wait states, every access completes in its first access cycle
   assign pready = 1'b1;
   assign wr_en = psel && penable && pwrite && addr_ok;
   assign rd_setup = psel && !penable && !pwrite;
   assign pslverr = psel && penable && !addr_ok;
   always_comb begin
      unique case (paddr)
         CDCO_ADDR_CLK_DIV, CDCO_ADDR_PIN_SEL, CDCO_ADDR_CLKO_EN,
         CDCO_ADDR_MISC, CDCO_ADDR_STATUS: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end

   // Clock division register; reserved bits keep zero
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         clk_div <= CDCO_CD_RESET;
      end else if (wr_en && paddr == CDCO_ADDR_CLK_DIV) begin
         clk_div <= pwdata[7:0] & CDCO_CD_WMASK;
      end
   end

   // Serial pin group select, reset to the alternate pair
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pin_grp <= CDCO_PS_GRP_RESET;
      end else if (wr_en && paddr == CDCO_ADDR_PIN_SEL) begin
         pin_grp <= pwdata[CDCO_PS_GRP_LSB +: 2];
      end
   end

   // Timer clock output enables
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         clko_en <= 8'h00;
      end else if (wr_en && paddr == CDCO_ADDR_CLKO_EN) begin
         clko_en <= pwdata[7:0] & CDCO_CE_WMASK;
      end
   end

   // Misc control: shared pin I/O, reset indicator, clock source
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         misc <= CDCO_MC_RESET;
      end else if (wr_en && paddr == CDCO_ADDR_MISC) begin
         misc <= pwdata[7:0] & CDCO_MC_WMASK;
      end
   end

   // Read mux
   always_comb begin
      next_rdata = 32'h0000_0000;
      unique case (paddr)
         CDCO_ADDR_CLK_DIV: next_rdata[7:0] = clk_div;
         CDCO_ADDR_PIN_SEL: next_rdata[CDCO_PS_GRP_LSB +: 2] = pin_grp;
         CDCO_ADDR_CLKO_EN: next_rdata[7:0] = clko_en;
         CDCO_ADDR_MISC: next_rdata[7:0] = misc;
         CDCO_ADDR_STATUS: next_rdata[9:0] =
            {out_sel_act, 1'b0, div_exp, 1'b0, reset_request, shared_pin_in, rst_mode};
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   // Read data captured in the setup cycle, stable through the access cycle
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         prdata <= 32'h0000_0000;
      end else if (rd_setup) begin
         prdata <= next_rdata;
      end
   end

   // Master clock source select, reserved code falls back to the RC oscillator
   always_comb begin
      unique case (misc[CDCO_MC_SRC_LSB +: 2])
         CDCO_SRC_EXT_IN: master_clock_source = 3'b010;
         CDCO_SRC_XTAL: master_clock_source = 3'b100;
         default: master_clock_source = 3'b001;
      endcase
   end

   // System clock prescaler; new divisor is loaded only at a period boundary
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         div_cnt <= 7'h00;
         div_exp <= 3'h0;
         div_mask <= 7'h00;
         sysclk_tick <= 1'b0;
      end else if (div_cnt >= div_mask) begin
         div_cnt <= 7'h00;
         div_exp <= clk_div[CDCO_CD_DIV_LSB +: 3];
         div_mask <= 7'((8'h01 << clk_div[CDCO_CD_DIV_LSB +: 3]) - 8'h01);
         sysclk_tick <= 1'b1;
      end else begin
         div_cnt <= div_cnt + 7'h01;
         sysclk_tick <= 1'b0;
      end
   end

   // Master clock output divider
   cdco_clkout u_clkout (
      .core_clk(core_clk),
      .nrst(nrst),
      .sel(clk_div[CDCO_CD_OUTSEL_LSB +: 2]),
      .sel_act(out_sel_act),
      .clk_out(mclk_out)
   );

   // Programming option caught on the first edge after reset release
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         strap_taken <= 1'b0;
         rst_mode <= 1'b0;
      end else if (!strap_taken) begin
         strap_taken <= 1'b1;
         rst_mode <= reset_pin_option;
      end
   end

   // Reset pin filter: request after two consecutive high cycles
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rst_hi_cnt <= 2'h0;
         reset_request <= 1'b0;
      end else if (rst_mode && shared_pin_in) begin
         if (rst_hi_cnt != CDCO_RST_MIN_CYC) begin
            rst_hi_cnt <= rst_hi_cnt + 2'h1;
         end
         reset_request <= (rst_hi_cnt >= CDCO_RST_MIN_CYC - 2'h1);
      end else begin
         rst_hi_cnt <= 2'h0;
         reset_request <= 1'b0;
      end
   end

   // Shared pin: reset input, else clock output, else general I/O
   always_comb begin
      if (rst_mode) begin
         shared_pin_out = 1'b0;
         shared_pin_oe_n = 1'b1;
      end else if (out_sel_act != CDCO_OUT_OFF) begin
         shared_pin_out = mclk_out;
         shared_pin_oe_n = 1'b0;
      end else begin
         shared_pin_out = misc[CDCO_MC_GPIO_OUT_BIT];
         shared_pin_oe_n = !misc[CDCO_MC_GPIO_DRV_BIT];
      end
   end

   // Reset indicator low from reset until software raises it
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         reset_indicator_output <= 1'b0;
      end else begin
         reset_indicator_output <= misc[CDCO_MC_RSTOUT_BIT];
      end
   end

   // Active serial group, code 3 falls back to the default pair
   assign act_grp = (pin_grp == 2'h3) ? 2'h0 : pin_grp;
   assign relay = clk_div[CDCO_CD_RELAY_BIT];

   // Receive line from the active pair to the serial port
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         serial_rx_data <= 1'b1;
      end else begin
         serial_rx_data <= serial_rx_pin[act_grp];
      end
   end

   // Transmit pins per group: idle high and released unless selected
   for (genvar g = 0; g < CDCO_NGRP; g++) begin : g_ser
      always_ff @(posedge core_clk or negedge nrst) begin
         if (!nrst) begin
            serial_tx_pin[g] <= 1'b1;
            serial_tx_pin_oe_n[g] <= 1'b1;
         end else if (act_grp == 2'(g)) begin
            serial_tx_pin_oe_n[g] <= 1'b0;
            if (relay) begin
               serial_tx_pin[g] <= serial_rx_pin[g];
            end else begin
               serial_tx_pin[g] <= serial_tx_data;
            end
         end else begin
            serial_tx_pin[g] <= 1'b1;
            serial_tx_pin_oe_n[g] <= 1'b1;
         end
      end
   end

   // Timer clock outputs gated by their enable bits
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         timer0_clock_output <= 1'b0;
         timer0_clock_output_oe_n <= 1'b1;
         timer2_clock_output <= 1'b0;
         timer2_clock_output_oe_n <= 1'b1;
      end else begin
         timer0_clock_output <= timer0_clock_in & clko_en[CDCO_CE_T0_BIT];
         timer0_clock_output_oe_n <= !clko_en[CDCO_CE_T0_BIT];
         timer2_clock_output <= timer2_clock_in & clko_en[CDCO_CE_T2_BIT];
         timer2_clock_output_oe_n <= !clko_en[CDCO_CE_T2_BIT];
      end
   end

   property p_div8_period;
      @(posedge core_clk) disable iff (!nrst)
      sysclk_tick && div_exp == 3'h3 |=> !sysclk_tick [*7] ##1 sysclk_tick;
   endproperty
   a_div8_period: assert property (p_div8_period) else $error("divide by eight period wrong");

   property p_div1_tick;
      @(posedge core_clk) disable iff (!nrst)
      sysclk_tick && div_exp == 3'h0 |=> sysclk_tick;
   endproperty
   a_div1_tick: assert property (p_div1_tick) else $error("undivided tick missing");

   property p_relay;
      @(posedge core_clk) disable iff (!nrst)
      relay && act_grp == 2'h1 |=> serial_tx_pin[1] == $past(serial_rx_pin[1]);
   endproperty
   a_relay: assert property (p_relay) else $error("relay does not mirror receive");

   property p_normal_tx;
      @(posedge core_clk) disable iff (!nrst)
      !relay && act_grp == 2'h0 |=> serial_tx_pin[0] == $past(serial_tx_data)
         && !serial_tx_pin_oe_n[0] && serial_tx_pin_oe_n[1];
   endproperty
   a_normal_tx: assert property (p_normal_tx) else $error("transmit pin not driven");

   property p_rst_pin;
      @(posedge core_clk) disable iff (!nrst)
      rst_mode && shared_pin_in ##1 rst_mode && shared_pin_in |=> reset_request;
   endproperty
   a_rst_pin: assert property (p_rst_pin) else $error("reset pin not honoured");

   property p_rst_short;
      @(posedge core_clk) disable iff (!nrst)
      !(rst_mode && shared_pin_in) |=> !reset_request ##1 !reset_request;
   endproperty
   a_rst_short: assert property (p_rst_short) else $error("reset on a short pulse");

   property p_rstout;
      @(posedge core_clk) disable iff (!nrst)
      wr_en && paddr == CDCO_ADDR_MISC |=> ##1
         reset_indicator_output == $past(pwdata[CDCO_MC_RSTOUT_BIT], 2);
   endproperty
   a_rstout: assert property (p_rstout) else $error("reset indicator wrong");

   property p_t0_gate;
      @(posedge core_clk) disable iff (!nrst)
      !clko_en[CDCO_CE_T0_BIT] |=> timer0_clock_output_oe_n && !timer0_clock_output;
   endproperty
   a_t0_gate: assert property (p_t0_gate) else $error("timer 0 output while disabled");

   property p_reserved;
      @(posedge core_clk) disable iff (!nrst)
      wr_en && paddr == CDCO_ADDR_CLK_DIV |=> clk_div[5] == 1'b0 && clk_div[3] == 1'b0;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits written");

   c_relay: cover property (@(posedge core_clk) disable iff (!nrst) relay && act_grp == 2'h2);
   c_div128: cover property (@(posedge core_clk) disable iff (!nrst)
      sysclk_tick && div_exp == 3'h7);
   c_rst: cover property (@(posedge core_clk) disable iff (!nrst) $rose(reset_request));
endmodule

// ==== inc/cdco_pkg.sv ====
package cdco_pkg;
   // Core clock rate
   localparam int CDCO_CLK_HZ = 25_000_000;

   // Register indices (printed offsets) and byte addresses (index times four)
   localparam logic [9:0] CDCO_IDX_CLK_DIV = 10'h097;
   localparam logic [9:0] CDCO_IDX_PIN_SEL = 10'h0A2;
   localparam logic [9:0] CDCO_IDX_CLKO_EN = 10'h0C0;
   localparam logic [9:0] CDCO_IDX_MISC = 10'h0C1;
   localparam logic [9:0] CDCO_IDX_STATUS = 10'h0C2;
   localparam logic [11:0] CDCO_ADDR_CLK_DIV = {CDCO_IDX_CLK_DIV, 2'b00};
   localparam logic [11:0] CDCO_ADDR_PIN_SEL = {CDCO_IDX_PIN_SEL, 2'b00};
   localparam logic [11:0] CDCO_ADDR_CLKO_EN = {CDCO_IDX_CLKO_EN, 2'b00};
   localparam logic [11:0] CDCO_ADDR_MISC = {CDCO_IDX_MISC, 2'b00};
   localparam logic [11:0] CDCO_ADDR_STATUS = {CDCO_IDX_STATUS, 2'b00};

   // Clock division register fields
   localparam int CDCO_CD_OUTSEL_LSB = 6;
   localparam int CDCO_CD_RELAY_BIT = 4;
   localparam int CDCO_CD_DIV_LSB = 0;
   localparam logic [7:0] CDCO_CD_WMASK = 8'hD7;
   localparam logic [7:0] CDCO_CD_RESET = 8'h00;

   // Pin group select register fields
   localparam int CDCO_PS_GRP_LSB = 6;
   localparam logic [1:0] CDCO_PS_GRP_RESET = 2'h1;

   // Clock output enable register fields
   localparam int CDCO_CE_T0_BIT = 0;
   localparam int CDCO_CE_T2_BIT = 2;
   localparam logic [7:0] CDCO_CE_WMASK = 8'h05;

   // Misc control register fields
   localparam int CDCO_MC_GPIO_OUT_BIT = 0;
   localparam int CDCO_MC_GPIO_DRV_BIT = 1;
   localparam int CDCO_MC_RSTOUT_BIT = 2;
   localparam int CDCO_MC_SRC_LSB = 4;
   localparam logic [7:0] CDCO_MC_WMASK = 8'h37;
   localparam logic [7:0] CDCO_MC_RESET = 8'h00;

   // Clock output select codes
   localparam logic [1:0] CDCO_OUT_OFF = 2'h0;
   localparam logic [1:0] CDCO_OUT_DIV1 = 2'h1;
   localparam logic [1:0] CDCO_OUT_DIV2 = 2'h2;
   localparam logic [1:0] CDCO_OUT_DIV4 = 2'h3;

   // Master clock source codes
   localparam logic [1:0] CDCO_SRC_RC = 2'h0;
   localparam logic [1:0] CDCO_SRC_EXT_IN = 2'h1;
   localparam logic [1:0] CDCO_SRC_XTAL = 2'h2;

   // Reset pin must be high this many machine cycles (one clock each)
   localparam int CDCO_RST_MIN_MC = 2;
   localparam logic [1:0] CDCO_RST_MIN_CYC = 2'(CDCO_RST_MIN_MC);
   localparam int CDCO_NGRP = 3;
endpackage

// ==== rtl/cdco_clkout.sv ====
module cdco_clkout
   import cdco_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic [1:0] sel,
   output logic [1:0] sel_act,
   output logic clk_out
);
   logic [1:0] cnt;
   logic [1:0] next_cnt;
   logic [1:0] next_sel;
   logic div_q;
   logic en_neg;

   // Select changes only at the end of a four-cycle frame, on the edge where divided phases fall low
   assign next_cnt = cnt + 2'h1;
   assign next_sel = (cnt == 2'h3) ? sel : sel_act;

   // Divided phase flop and frame counter
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cnt <= 2'h0;
         sel_act <= CDCO_OUT_OFF;
         div_q <= 1'b0;
      end else begin
         cnt <= next_cnt;
         sel_act <= next_sel;
         unique case (next_sel)
            CDCO_OUT_DIV2: div_q <= next_cnt[0];
            CDCO_OUT_DIV4: div_q <= next_cnt[1];
            default: div_q <= 1'b0;
         endcase
      end
   end

   // Undivided gate enable moves while the clock is low, so no runt pulse
   always_ff @(negedge core_clk or negedge nrst) begin
      if (!nrst) begin
         en_neg <= 1'b0;
      end else begin
         en_neg <= (sel_act == CDCO_OUT_DIV1);
      end
   end

   // Undivided path gated, divided paths from the phase flop
   assign clk_out = (core_clk & en_neg) | div_q;

   property p_off_quiet;
      @(posedge core_clk) disable iff (!nrst)
      (sel_act == CDCO_OUT_OFF) ##1 (sel_act == CDCO_OUT_OFF) |-> !div_q && !en_neg;
   endproperty
   a_off_quiet: assert property (p_off_quiet) else $error("clock out active while off");

   property p_div1_gate;
      @(posedge core_clk) disable iff (!nrst)
      (sel_act == CDCO_OUT_DIV1) [*2] |-> en_neg && !div_q;
   endproperty
   a_div1_gate: assert property (p_div1_gate) else $error("undivided output not gated on");

   property p_div2_toggle;
      @(posedge core_clk) disable iff (!nrst)
      (sel_act == CDCO_OUT_DIV2) [*2] |-> div_q != $past(div_q);
   endproperty
   a_div2_toggle: assert property (p_div2_toggle) else $error("divide by two not toggling");

   property p_div4_period;
      @(posedge core_clk) disable iff (!nrst)
      (sel_act == CDCO_OUT_DIV4) && $rose(div_q) |-> div_q ##1 div_q ##1 !div_q [*2]
         ##1 (div_q || sel_act != CDCO_OUT_DIV4);
   endproperty
   a_div4_period: assert property (p_div4_period) else $error("divide by four period wrong");

   c_div4: cover property (@(posedge core_clk) disable iff (!nrst)
      (sel_act == CDCO_OUT_DIV4) && $rose(div_q));
endmodule

// ==== sim/cdco_clk_sink.sv ====
// Circuit on the shared pin: watches the clock output and may hold the pin high
module cdco_clk_sink (
   input wire logic pin_out,
   input wire logic pin_oe_n,
   input wire logic drive_req,
   output logic pin_level,
   output int edge_cnt,
   output time edge_per
);
   timeunit 1ns;
   timeprecision 1ns;
   time last_t = 0;
   time per = 0;
   int cnt = 0;
   // Device drive wins; otherwise this circuit pulls the line low or holds it high
   assign pin_level = !pin_oe_n ? pin_out : drive_req;
   // Every rising edge counts, so a runt or glitch shows up as a short period
   always @(posedge pin_level) begin
      per = $time - last_t;
      last_t = $time;
      cnt++;
   end
   assign edge_cnt = cnt;
   assign edge_per = per;
endmodule

// ==== sim/cdco_top_tb_top.sv ====
module cdco_top_tb_top
   import cdco_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk, nrst, psel, penable, pwrite, reset_pin_option, serial_tx_data, er;
   logic timer0_clock_in, timer2_clock_in, drive_req, shared_pin_in, pready, pslverr;
   logic sysclk_tick, shared_pin_out, shared_pin_oe_n, reset_request, reset_indicator_output;
   logic serial_rx_data, timer0_clock_output, timer0_clock_output_oe_n;
   logic timer2_clock_output, timer2_clock_output_oe_n;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0] master_clock_source, serial_rx_pin, serial_tx_pin, serial_tx_pin_oe_n;
   logic [7:0] v;
   int err_count, checks_done, edge_cnt, seed, n0, p, gg;
   time edge_per;

   cdco_top dut (.core_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .sysclk_tick, .master_clock_source, .reset_pin_option, .shared_pin_in,
      .shared_pin_out, .shared_pin_oe_n, .reset_request, .reset_indicator_output,
      .serial_tx_data, .serial_rx_data, .serial_rx_pin, .serial_tx_pin, .serial_tx_pin_oe_n,
      .timer0_clock_in, .timer2_clock_in, .timer0_clock_output, .timer0_clock_output_oe_n,
      .timer2_clock_output, .timer2_clock_output_oe_n);
   cdco_clk_sink sink (.pin_out(shared_pin_out), .pin_oe_n(shared_pin_oe_n), .drive_req,
      .pin_level(shared_pin_in), .edge_cnt, .edge_per);

   // 25 MHz core clock
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   function automatic int exp_per(input logic [2:0] e);
      return 1 << e;
   endfunction

   function automatic int out_per(input logic [1:0] s);
      return 40 << (s - 2'h1);
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One APB transfer; held until pready is seen high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) err_count++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rst_cycle(input logic opt);
      @(posedge core_clk);
      nrst <= 1'b0;
      reset_pin_option <= opt;
      repeat (10) @(posedge core_clk);
      nrst <= 1'b1;
   endtask

   // Cycles from one system tick to the next, sampled away from the edge
   task automatic tick_per();
      int n;
      n = 0;
      do begin
         @(negedge core_clk);
         n++;
      end while (sysclk_tick !== 1'b1 && n < 300);
      p = 0;
      do begin
         @(negedge core_clk);
         p++;
      end while (sysclk_tick !== 1'b1 && p < 300);
   endtask

   task automatic give_verdict();
      $display("checks=%0d mismatches=%0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Hang guard well beyond the expected run length
   initial begin
      #(40 * 40000);
      err_count++;
      give_verdict();
   end

   initial begin
      seed = 32'ha3ba;
      {nrst, psel, penable, pwrite, reset_pin_option, serial_tx_data, drive_req} = '0;
      {timer0_clock_in, timer2_clock_in} = '0;
      paddr = '0;
      pwdata = '0;
      serial_rx_pin = 3'h7;
      rst_cycle(1'b0);
      apb(1'b0, CDCO_ADDR_CLK_DIV, '0);
      chk(rd, {24'h0, CDCO_CD_RESET});
      apb(1'b0, CDCO_ADDR_PIN_SEL, '0);
      chk(rd, 32'h0000_0040);
      chk(reset_indicator_output, 1'b0);
      chk(shared_pin_oe_n, 1'b1);
      apb(1'b1, CDCO_ADDR_CLK_DIV, 32'h0000_00ff);
      apb(1'b0, CDCO_ADDR_CLK_DIV, '0);
      chk(rd, {24'h0, CDCO_CD_WMASK});
      apb(1'b1, 12'h010, 32'h0000_00ff);
      chk(er, 1'b1);
      $display("done: reset values and reserved bits");
      // Every divide code, starting at a random one
      n0 = $random(seed);
      for (int i = 0; i < 8; i++) begin
         v = 8'((i + n0) & 7);
         apb(1'b1, CDCO_ADDR_CLK_DIV, {29'h0, v[2:0]});
         tick_per();
         tick_per();
         chk(32'(p), 32'(exp_per(v[2:0])));
      end
      $display("done: system clock divide");
      // Clock output codes, then off
      for (int s = 1; s < 4; s++) begin
         apb(1'b1, CDCO_ADDR_CLK_DIV, {24'h0, 2'(s), 6'h0});
         repeat (12) @(posedge core_clk);
         chk(shared_pin_oe_n, 1'b0);
         repeat (12) @(posedge core_clk);
         chk(32'(edge_per), 32'(out_per(2'(s))));
      end
      apb(1'b1, CDCO_ADDR_CLK_DIV, '0);
      repeat (12) @(posedge core_clk);
      n0 = edge_cnt;
      repeat (20) @(posedge core_clk);
      chk(32'(edge_cnt), 32'(n0));
      chk(shared_pin_oe_n, 1'b1);
      $display("done: clock output");
      // Master clock source codes; code 3 falls back to the RC oscillator
      for (int c = 0; c < 4; c++) begin
         apb(1'b1, CDCO_ADDR_MISC, {26'h0, 2'(c), 4'h0});
         @(negedge core_clk);
         chk(master_clock_source, (c == 3) ? 3'h1 : 3'(1 << c));
      end
      apb(1'b1, CDCO_ADDR_MISC, 32'h0000_0004);
      repeat (2) @(negedge core_clk);
      chk(reset_indicator_output, 1'b1);
      // Shared pin as driven general I/O, level high
      apb(1'b1, CDCO_ADDR_MISC, 32'h0000_0003);
      @(negedge core_clk);
      chk({shared_pin_oe_n, shared_pin_in}, 2'b01);
      $display("done: source and reset indicator");
      // Pin groups, relay on then off, random line levels
      for (int g = 0; g < 4; g++) begin
         gg = (g == 3) ? 0 : g;
         apb(1'b1, CDCO_ADDR_PIN_SEL, 32'(g << 6));
         apb(1'b1, CDCO_ADDR_CLK_DIV, 32'h0000_0010);
         serial_rx_pin <= 3'($random(seed));
         serial_tx_data <= 1'($random(seed));
         repeat (3) @(negedge core_clk);
         chk(serial_tx_pin_oe_n, 3'(~(3'h1 << gg)));
         chk(serial_rx_data, serial_rx_pin[gg]);
         chk(serial_tx_pin[gg], serial_rx_pin[gg]);
         apb(1'b1, CDCO_ADDR_CLK_DIV, '0);
         repeat (3) @(negedge core_clk);
         chk(serial_tx_pin[gg], serial_tx_data);
      end
      $display("done: serial routing and relay");
      // Timer clock output enables in all four combinations
      for (int k = 0; k < 4; k++) begin
         v = 8'({k[1], 1'b0, k[0]});
         apb(1'b1, CDCO_ADDR_CLKO_EN, {24'h0, v});
         timer0_clock_in <= 1'($random(seed));
         timer2_clock_in <= 1'($random(seed));
         repeat (3) @(negedge core_clk);
         chk({timer2_clock_output_oe_n, timer0_clock_output_oe_n}, 2'(~{v[2], v[0]}));
         if (v[0]) chk(timer0_clock_output, timer0_clock_in);
         if (v[2]) chk(timer2_clock_output, timer2_clock_in);
      end
      $display("done: timer clock outputs");
      // Shared pin strapped as reset input
      rst_cycle(1'b1);
      repeat (3) @(posedge core_clk);
      chk(shared_pin_oe_n, 1'b1);
      // Status: reset mode set, pin low, no request, divide and select idle
      apb(1'b0, CDCO_ADDR_STATUS, '0);
      chk(rd, 32'h0000_0001);
      drive_req <= 1'b1;
      @(posedge core_clk);
      drive_req <= 1'b0;
      for (int i = 0; i < 3; i++) begin
         @(negedge core_clk);
         chk(reset_request, 1'b0);
      end
      @(posedge core_clk);
      drive_req <= 1'b1;
      repeat (4) @(posedge core_clk);
      @(negedge core_clk);
      chk(reset_request, 1'b1);
      @(posedge core_clk);
      drive_req <= 1'b0;
      repeat (3) @(negedge core_clk);
      chk(reset_request, 1'b0);
      $display("done: reset pin");
      give_verdict();
   end
endmodule
